/* File: bac_area_ctrl.sv */
// Bus area control register with Avalon-MM slave, decoded area configuration and pin control.
// Assumes power-on reset on rst_n_i; manual reset and standby arrive as inputs that do not clear it.
`timescale 1ns/10ps
module bac_area_ctrl (
    // Clock, reset, enable
    input  wire logic                        ref_clk_i,
    input  wire logic                        rst_n_i,
    input  wire logic                        clk_en_i,
    // Avalon-MM slave
    input  wire logic [bac_pkg::ADDR_W-1:0]  avs_address_i,
    input  wire logic                        avs_read_i,
    input  wire logic                        avs_write_i,
    input  wire logic [bac_pkg::BUS_DW-1:0]  avs_writedata_i,
    input  wire logic [3:0]                  avs_byteenable_i,
    output logic [bac_pkg::BUS_DW-1:0]       avs_readdata_o,
    output logic                             avs_waitrequest_o,
    output logic [1:0]                       avs_response_o,
    // Chip state
    input  wire logic                        manual_reset_i,
    input  wire logic                        standby_i,
    input  wire logic                        bus_release_i,
    input  wire logic                        bus_grant_ack_i,
    input  wire logic                        data_bus_busy_i,
    input  wire logic                        byte_order_strap_i,
    // Decoded configuration and pin control
    output bac_pkg::bac_cfg_s                cfg_o,
    output bac_pkg::bac_pin_s                pin_o
);
    import bac_pkg::*;

    logic [REG_W-1:0] bus_area_control;
    logic             strap_level;
    logic             strap_taken;
    logic             ack;
    logic             hit_ctrl;
    logic             hit_stat;
    logic [2:0]       pu_count;
    logic             bga_prev;
    logic [REG_W-1:0] next_ctrl;
    bac_burst_cfg_s   dec_a0;
    bac_burst_cfg_s   dec_a5;
    bac_burst_cfg_s   dec_a6;

    bac_strap_sync u_strap (
        .ref_clk_i (ref_clk_i),
        .rst_n_i   (rst_n_i),
        .clk_en_i  (clk_en_i),
        .pin_i     (byte_order_strap_i),
        .level_o   (strap_level)
    );

    // One-cycle answer: waitrequest is high on the first cycle of a request and low on the second.
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            ack <= 1'b0;
        end else if (clk_en_i) begin
            ack <= (avs_read_i || avs_write_i) && !ack;
        end
    end

    assign avs_waitrequest_o = (avs_read_i || avs_write_i) && !ack;
    assign hit_ctrl = (avs_address_i == OFS_AREA_CTRL);
    assign hit_stat = (avs_address_i == OFS_STATUS);

    always_comb begin
        next_ctrl = bus_area_control;
        if (avs_byteenable_i[0]) begin
            next_ctrl[7:0] = avs_writedata_i[7:0];
        end
        if (avs_byteenable_i[1]) begin
            next_ctrl[15:8] = avs_writedata_i[15:8];
        end
        next_ctrl = (next_ctrl & WRITE_MASK) | (bus_area_control & ~WRITE_MASK);
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            bus_area_control <= AREA_CTRL_RESET;
        end else if (clk_en_i) begin
            if (avs_write_i && ack && hit_ctrl) begin
                bus_area_control <= next_ctrl;
            end
            if (!strap_taken) begin
                bus_area_control[BIT_ENDIAN] <= strap_level;
            end
        end
    end

    // The synchroniser output is first valid one edge after its three stages have filled.
    // An earlier capture would latch the reset level of the stages instead of the strap.
    logic [2:0] strap_wait;
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            strap_wait  <= 3'h0;
            strap_taken <= 1'b0;
        end else if (clk_en_i && !strap_taken) begin
            strap_wait <= strap_wait + 3'h1;
            if (strap_wait == 3'(STRAP_SYNC_LEN + 1)) begin
                strap_taken <= 1'b1;
            end
        end
    end

    // Read data; unmapped addresses read zero with a slave error response.
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            avs_readdata_o <= '0;
            avs_response_o <= 2'h0;
        end else if (clk_en_i && (avs_read_i || avs_write_i) && !ack) begin
            avs_response_o <= (hit_ctrl || hit_stat) ? 2'h0 : 2'h2;
            if (hit_ctrl) begin
                avs_readdata_o <= {16'h0000, bus_area_control};
            end else if (hit_stat) begin
                avs_readdata_o <= {27'h0000000, cfg_o.memtype_bad, pu_count, strap_taken};
            end else begin
                avs_readdata_o <= '0;
            end
        end
    end

    bac_burst_decode u_dec_a0 (
        .field_i (bus_area_control[LSB_A0_BURST+:2]),
        .cfg_o   (dec_a0)
    );
    bac_burst_decode u_dec_a5 (
        .field_i (bus_area_control[LSB_A5_BURST+:2]),
        .cfg_o   (dec_a5)
    );
    bac_burst_decode u_dec_a6 (
        .field_i (bus_area_control[LSB_A6_BURST+:2]),
        .cfg_o   (dec_a6)
    );

    always_comb begin
        cfg_o.area0         = dec_a0;
        cfg_o.area5         = dec_a5;
        cfg_o.area6         = dec_a6;
        cfg_o.area2_sdram   = 1'b0;
        cfg_o.area3_sdram   = 1'b0;
        cfg_o.memtype_bad   = 1'b0;
        cfg_o.area5_card    = bus_area_control[BIT_A5_CARD];
        cfg_o.area6_card    = bus_area_control[BIT_A6_CARD];
        cfg_o.little_endian = bus_area_control[BIT_ENDIAN];
        case (bac_memtype_e'(bus_area_control[LSB_MEMTYPE+:3]))
            BAC_MT_ORDINARY: cfg_o.memtype_bad = 1'b0;
            BAC_MT_A3_SDRAM: cfg_o.area3_sdram = 1'b1;
            BAC_MT_BOTH_SD: begin
                cfg_o.area2_sdram = 1'b1;
                cfg_o.area3_sdram = 1'b1;
            end
            default: cfg_o.memtype_bad = 1'b1;
        endcase
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            bga_prev <= 1'b0;
            pu_count <= 3'h0;
        end else if (clk_en_i) begin
            bga_prev <= bus_grant_ack_i;
            if (bus_grant_ack_i && !bga_prev && bus_area_control[BIT_ADDR_PU]) begin
                pu_count <= 3'(ADDR_PU_CYCLES);
            end else if (pu_count != 3'h0) begin
                pu_count <= pu_count - 3'h1;
            end
        end
    end

    // Pin controls are registered so that all pin control outputs come from flip-flops.
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            pin_o <= '0;
        end else if (clk_en_i) begin
            pin_o.addr_pullup <= (bus_grant_ack_i && !bga_prev && bus_area_control[BIT_ADDR_PU])
                                 || (pu_count > 3'h1);
            pin_o.data_pullup <= bus_area_control[BIT_DATA_PU] && !data_bus_busy_i;
            pin_o.mem_oe   <= !standby_i || bus_area_control[BIT_MEM_DRV];
            pin_o.mem_high <= standby_i && bus_area_control[BIT_MEM_DRV];
            pin_o.strobe_oe <= !(standby_i || bus_release_i) || bus_area_control[BIT_STB_DRV];
        end
    end

    // Assertions.
    sequence s_grant_rise;
        bus_grant_ack_i && !bga_prev && bus_area_control[BIT_ADDR_PU] && clk_en_i;
    endsequence

    chk_addr_pullup_len: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        s_grant_rise ##1 clk_en_i [*4] |-> $past(pin_o.addr_pullup, 3))
        else $error("address pull-up window too short");
    chk_pullup_off: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        (pu_count == 3'h0) && !bga_prev ##1 clk_en_i |-> !pin_o.addr_pullup || $past(bus_grant_ack_i))
        else $error("address pull-up without grant");
    chk_data_pullup: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        clk_en_i |=> pin_o.data_pullup == ($past(bus_area_control[BIT_DATA_PU]) && !$past(data_bus_busy_i)))
        else $error("data pull-up wrong");
    chk_standby_mem: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        clk_en_i && standby_i |=> pin_o.mem_oe == $past(bus_area_control[BIT_MEM_DRV]))
        else $error("standby memory drive wrong");
    chk_strobe_rel: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        clk_en_i && bus_release_i && !bus_area_control[BIT_STB_DRV] |=> !pin_o.strobe_oe)
        else $error("strobe driven during release");
    chk_endian_ro: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        strap_taken |=> $stable(bus_area_control[BIT_ENDIAN]))
        else $error("byte-order flag changed");
    chk_write_take: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        clk_en_i && avs_write_i && ack && hit_ctrl && (avs_byteenable_i == 4'hf)
        |=> (bus_area_control & WRITE_MASK) == ($past(avs_writedata_i[15:0]) & WRITE_MASK))
        else $error("write not taken");
    chk_hold_manual: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        (manual_reset_i || standby_i) && !avs_write_i && strap_taken |=> $stable(bus_area_control))
        else $error("register lost in manual reset or standby");
    chk_burst_beats: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        bus_area_control[LSB_A0_BURST+:2] == 2'h3 |-> cfg_o.area0.burst && cfg_o.area0.beats == 5'h10)
        else $error("area 0 burst decode wrong");
    chk_memtype: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        bus_area_control[LSB_MEMTYPE+:3] == 3'h2 |-> cfg_o.area3_sdram && !cfg_o.area2_sdram)
        else $error("memory type decode wrong");
    chk_wait_once: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        (avs_read_i || avs_write_i) && !ack && clk_en_i |=> !avs_waitrequest_o || !(avs_read_i || avs_write_i))
        else $error("waitrequest held too long");
endmodule

/* File: bac_pkg.sv */
// Package for the bus area control register block: field layout, reset values, decoded types.
// Assumes a single 40 MHz clock domain and an Avalon-MM slave with 32-bit data words.

package bac_pkg;

    localparam int REG_W = 16;
    localparam int BUS_DW = 32;
    localparam int ADDR_W = 4;

    // Register byte addresses on the slave.
    localparam logic [ADDR_W-1:0] OFS_AREA_CTRL = 4'h0;
    localparam logic [ADDR_W-1:0] OFS_STATUS    = 4'h4;

    localparam logic [REG_W-1:0] AREA_CTRL_RESET = 16'h0000;

    localparam int BIT_ADDR_PU  = 15;
    localparam int BIT_DATA_PU  = 14;
    localparam int BIT_MEM_DRV  = 13;
    localparam int BIT_STB_DRV  = 12;
    localparam int BIT_ENDIAN   = 11;
    localparam int LSB_A0_BURST = 9;
    localparam int LSB_A5_BURST = 7;
    localparam int LSB_A6_BURST = 5;
    localparam int LSB_MEMTYPE  = 2;
    localparam int BIT_A5_CARD  = 1;
    localparam int BIT_A6_CARD  = 0;

    // Bits software may change; the byte-order flag is excluded.
    localparam logic [REG_W-1:0] WRITE_MASK = 16'hf7ff;

    localparam int ADDR_PU_CYCLES = 4;
    localparam int STRAP_SYNC_LEN = 3;

    typedef enum logic [1:0] {
        BAC_BURST_NONE = 2'b00,
        BAC_BURST_4    = 2'b01,
        BAC_BURST_8    = 2'b10,
        BAC_BURST_16   = 2'b11
    } bac_burst_e;

    typedef enum logic [2:0] {
        BAC_MT_ORDINARY = 3'b000,
        BAC_MT_A3_SDRAM = 3'b010,
        BAC_MT_BOTH_SD  = 3'b011
    } bac_memtype_e;

    typedef struct packed {
        logic [4:0] beats;
        logic       burst;
    } bac_burst_cfg_s;

    typedef struct packed {
        bac_burst_cfg_s area0;
        bac_burst_cfg_s area5;
        bac_burst_cfg_s area6;
        logic           area2_sdram;
        logic           area3_sdram;
        logic           memtype_bad;
        logic           area5_card;
        logic           area6_card;
        logic           little_endian;
    } bac_cfg_s;

    typedef struct packed {
        logic mem_oe;
        logic mem_high;
        logic strobe_oe;
        logic addr_pullup;
        logic data_pullup;
    } bac_pin_s;

endpackage

/* File: bac_strap_sync.sv */
// Three-stage synchroniser for the byte-order strap pin.
// Assumes the strap is a slow level from outside the clock domain.
`timescale 1ns/10ps
module bac_strap_sync (
    // Clock and control
    input  wire logic ref_clk_i,
    input  wire logic rst_n_i,
    input  wire logic clk_en_i,
    // Pin and result
    input  wire logic pin_i,
    output logic      level_o
);
    import bac_pkg::*;

    logic [STRAP_SYNC_LEN-1:0] stage;

    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            stage <= '0;
        end else if (clk_en_i) begin
            stage <= {stage[STRAP_SYNC_LEN-2:0], pin_i};
        end
    end

    // Only the second and third stages are compared, so a metastable first stage is never seen.
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            level_o <= 1'b0;
        end else if (clk_en_i && (stage[1] == stage[2])) begin
            level_o <= stage[2];
        end
    end
endmodule

/* File: bac_burst_decode.sv */
// Decoder from a two-bit burst field to a burst enable and a beat count.
// Assumes a purely combinational use inside the register block.
`timescale 1ns/10ps
module bac_burst_decode (
    // Field in
    input  wire logic [1:0]                field_i,
    // Decoded result
    output bac_pkg::bac_burst_cfg_s        cfg_o
);
    import bac_pkg::*;

    always_comb begin
        cfg_o.burst = 1'b1;
        case (bac_burst_e'(field_i))
            BAC_BURST_4: cfg_o.beats = 5'h04;
            BAC_BURST_8: cfg_o.beats = 5'h08;
            BAC_BURST_16: cfg_o.beats = 5'h10;
            default: begin
                cfg_o.burst = 1'b0;
                cfg_o.beats = 5'h01;
            end
        endcase
    end
endmodule

/* File: tb.sv */
// Self-checking testbench for the bus area control register block.
// Assumes the byte-order strap held high throughout; requests wait for the slave's answer.
`timescale 1ns/10ps
module tb;
    import bac_pkg::*;
    logic                ref_clk = 1'b0;
    logic                rst_n = 1'b0;
    logic [ADDR_W-1:0]   address = '0;
    logic                read = 1'b0;
    logic                write = 1'b0;
    logic [BUS_DW-1:0]   writedata = '0;
    logic [BUS_DW-1:0]   readdata;
    logic                waitrequest;
    logic [1:0]          response;
    logic                manual_reset = 1'b0;
    logic                standby = 1'b0;
    logic                bus_release = 1'b0;
    logic                grant_ack = 1'b0;
    logic                busy = 1'b0;
    logic                clk_en = 1'b1;
    logic [3:0]          be = 4'hf;
    bac_cfg_s            cfg;
    bac_pin_s            pin;
    int                  fail_count = 0;
    int                  num_checks = 0;
    int                  cycles = 0;
    logic [31:0]         d;
    logic [1:0]          r;
    int                  n;

    bac_area_ctrl dut_u (
        .ref_clk_i(ref_clk), .rst_n_i(rst_n), .clk_en_i(clk_en),
        .avs_address_i(address), .avs_read_i(read), .avs_write_i(write),
        .avs_writedata_i(writedata), .avs_byteenable_i(be), .avs_readdata_o(readdata),
        .avs_waitrequest_o(waitrequest), .avs_response_o(response),
        .manual_reset_i(manual_reset), .standby_i(standby), .bus_release_i(bus_release),
        .bus_grant_ack_i(grant_ack), .data_bus_busy_i(busy), .byte_order_strap_i(1'b1),
        .cfg_o(cfg), .pin_o(pin)
    );

    always #12.5 ref_clk = ~ref_clk;

    // A hung handshake would otherwise stall the run forever.
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            fail_count = fail_count + 1;
            report_and_stop();
        end
    end

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks = num_checks + 1;
        if (seen !== exp) begin
            fail_count = fail_count + 1;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Request stays up until the rising edge where waitrequest is seen low; data is taken there.
    task automatic bus_op(input logic wr, input logic [3:0] a, input logic [31:0] wd,
                          output logic [31:0] rd, output logic [1:0] rs);
        logic done;
        address <= a;
        writedata <= wd;
        read <= ~wr;
        write <= wr;
        done = 1'b0;
        while (!done) begin
            @(posedge ref_clk);
            done = (waitrequest === 1'b0);
        end
        rd = readdata;
        rs = response;
        read <= 1'b0;
        write <= 1'b0;
        @(posedge ref_clk);
    endtask

    task automatic wr_reg(input logic [15:0] v);
        bus_op(1'b1, OFS_AREA_CTRL, {16'h0000, v}, d, r);
    endtask

    task automatic settle();
        repeat (2) @(negedge ref_clk);
        @(posedge ref_clk);
    endtask

    initial begin
        repeat (12) @(posedge ref_clk);
        rst_n <= 1'b1;
        @(posedge ref_clk);
        bus_op(1'b0, OFS_AREA_CTRL, 0, d, r);
        check(d & 32'h0000f7ff, 32'h0);
        n = 0;
        do begin
            bus_op(1'b0, OFS_STATUS, 0, d, r);
            n = n + 1;
        end while (d[0] !== 1'b1 && n < 20);
        bus_op(1'b0, OFS_AREA_CTRL, 0, d, r);
        check(d, 32'h00000800);
        $display("test reset done");

        wr_reg(16'h0000);
        bus_op(1'b0, OFS_AREA_CTRL, 0, d, r);
        check(d, 32'h00000800);
        wr_reg(16'hf7ff);
        bus_op(1'b0, OFS_AREA_CTRL, 0, d, r);
        check(d, 32'h0000ffff);
        check(cfg.little_endian, 1'b1);
        wr_reg(16'h52b4);
        manual_reset <= 1'b1;
        standby <= 1'b1;
        settle();
        bus_op(1'b0, OFS_AREA_CTRL, 0, d, r);
        check(d, 32'h00005ab4);
        manual_reset <= 1'b0;
        standby <= 1'b0;
        $display("test write done");

        for (int c = 0; c < 4; c++) begin
            wr_reg(16'((c << 9) | (c << 7) | (c << 5)));
            check(cfg.area0.burst, c != 0);
            check(cfg.area5.burst, c != 0);
            check(cfg.area6.burst, c != 0);
            if (c != 0) begin
                check(cfg.area0.beats, 4 << (c - 1));
                check(cfg.area5.beats, 4 << (c - 1));
                check(cfg.area6.beats, 4 << (c - 1));
            end
        end
        for (int m = 0; m < 8; m++) begin
            wr_reg(16'((m << 2) | (m & 3)));
            check(cfg.area2_sdram, m == 3);
            check(cfg.area3_sdram, m == 2 || m == 3);
            check(cfg.memtype_bad, m != 0 && m != 2 && m != 3);
            check(cfg.area5_card, m[1]);
            check(cfg.area6_card, m[0]);
        end
        $display("test decode done");

        for (int i = 0; i < 8; i++) begin
            wr_reg(i[1] ? 16'h7000 : 16'h0000);
            standby <= i[0];
            busy <= i[0];
            bus_release <= i[2];
            settle();
            check(pin.mem_oe, !i[0] || i[1]);
            check(pin.mem_high, i[0] && i[1]);
            check(pin.strobe_oe, !(i[0] || i[2]) || i[1]);
            check(pin.data_pullup, i[1] && !i[0]);
        end
        standby <= 1'b0;
        busy <= 1'b0;
        bus_release <= 1'b0;
        for (int k = 0; k < 2; k++) begin
            wr_reg(k ? 16'h8000 : 16'h0000);
            grant_ack <= 1'b1;
            n = 0;
            repeat (10) begin
                @(negedge ref_clk);
                n = n + (pin.addr_pullup === 1'b1);
            end
            @(posedge ref_clk);
            grant_ack <= 1'b0;
            settle();
            check(n, k ? 4 : 0);
        end
        clk_en <= 1'b0;
        standby <= 1'b1;
        settle();
        check(pin.mem_oe, 1'b1);
        clk_en <= 1'b1;
        settle();
        check(pin.mem_oe, 1'b0);
        standby <= 1'b0;
        $display("test pins done");

        wr_reg(16'h1234);
        bus_op(1'b0, 4'h8, 0, d, r);
        check(d, 32'h0);
        check(r, 2'b10);
        bus_op(1'b1, 4'h8, 32'h0000ffff, d, r);
        bus_op(1'b1, OFS_STATUS, 32'h0000ffff, d, r);
        bus_op(1'b0, OFS_AREA_CTRL, 0, d, r);
        check(d, 32'h00001a34);
        be <= 4'h1;
        wr_reg(16'hffff);
        be <= 4'hf;
        bus_op(1'b0, OFS_AREA_CTRL, 0, d, r);
        check(d, 32'h00001aff);
        $display("test unmapped done");

        wr_reg(16'hffff);
        rst_n <= 1'b0;
        repeat (2) @(posedge ref_clk);
        rst_n <= 1'b1;
        @(posedge ref_clk);
        bus_op(1'b0, OFS_AREA_CTRL, 0, d, r);
        check(d & 32'h0000f7ff, 32'h0);
        $display("test second reset done");
        report_and_stop();
    end
endmodule
